//--- src/spsf_map.svh
`ifndef SPSF_MAP_SVH
`define SPSF_MAP_SVH
`define SPSF_OP_WLATCH_SET 8'h06
`define SPSF_OP_WLATCH_CLR 8'h04
`define SPSF_OP_SR_RD 8'h05
`define SPSF_OP_SR_WR 8'h01
`define SPSF_OP_MEM_RD 8'h03
`define SPSF_OP_MEM_WR 8'h02
`define SPSF_OP_PC_RD 8'h13
`define SPSF_OP_PC_WR 8'h12
`define SPSF_SR_FIXED 8'h40
`define SPSF_SR_WEL_BIT 1
`define SPSF_SR_BP_LO 2
`define SPSF_SR_BP_HI 3
`define SPSF_SR_BP_MASK 8'h0c
`define SPSF_PC_RTC_CTRL 8'h00
`define SPSF_RTC_R_BIT 0
`define SPSF_PC_WRAP 8'h1d
`define SPSF_BIT_LAST 3'h7
`define SPSF_ADDR_W 15
`endif

//--- src/spsf_pkg.sv
package spsf_pkg;
  typedef enum logic [2:0] {
    SPSF_OPC = 3'b000,
    SPSF_AHI = 3'b001,
    SPSF_ALO = 3'b011,
    SPSF_DAT = 3'b010,
    SPSF_IGN = 3'b110
  } spsf_state_t;
endpackage

//--- src/spsf_edge_if.sv
`timescale 1ns/1ns
`default_nettype none
interface spsf_edge_if;
  logic sel;
  logic sel_fall;
  logic sck_rise;
  logic sck_fall;
  logic si;
  logic mode3;
  modport src (output sel, sel_fall, sck_rise, sck_fall, si, mode3);
  modport dst (input sel, sel_fall, sck_rise, sck_fall, si, mode3);
endinterface
`default_nettype wire

//--- src/spsf_pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
// two-flop sync then edge detect on the second stage only
module spsf_pin_sync (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  spsf_edge_if.src ev
);
  logic [2:0] m1_r, m2_r, prev_r;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      m1_r <= 3'h7;
      m2_r <= 3'h7;
      prev_r <= 3'h7;
    end else if (ce) begin
      m1_r <= {cs_n, sck, si};
      m2_r <= m1_r;
      prev_r <= m2_r;
    end
  end
  assign ev.sel = !m2_r[2];
  assign ev.sel_fall = prev_r[2] && !m2_r[2] && ce;
  assign ev.sck_rise = !prev_r[1] && m2_r[1] && ce && !m2_r[2];
  assign ev.sck_fall = prev_r[1] && !m2_r[1] && ce && !m2_r[2];
  assign ev.si = m2_r[0];
  assign ev.mode3 = m2_r[1];
endmodule // spsf_pin_sync
`default_nettype wire

//--- src/spsf_front.sv
`timescale 1ns/1ns
`default_nettype none
`include "spsf_map.svh"
module spsf_front (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  output logic so_o,
  output logic so_oe_n,
  output logic [14:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_we,
  output logic mem_re,
  input wire logic [7:0] mem_rdata,
  output logic [7:0] pc_addr,
  output logic [7:0] pc_wdata,
  output logic pc_we,
  output logic pc_re,
  input wire logic [7:0] pc_rdata,
  output logic time_capture,
  output logic [7:0] status_o,
  output logic mode3_o
);
  spsf_edge_if ev ();
  spsf_pin_sync u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .cs_n(cs_n),
    .sck(sck),
    .si(si),
    .ev(ev)
  );

  function automatic logic op_known(input logic [7:0] op);
    case (op)
      `SPSF_OP_WLATCH_SET, `SPSF_OP_WLATCH_CLR, `SPSF_OP_SR_RD, `SPSF_OP_SR_WR,
      `SPSF_OP_MEM_RD, `SPSF_OP_MEM_WR, `SPSF_OP_PC_RD, `SPSF_OP_PC_WR: op_known = 1'b1;
      default: op_known = 1'b0;
    endcase
  endfunction

  function automatic logic [7:0] pc_next(input logic [7:0] a);
    pc_next = (a >= `SPSF_PC_WRAP) ? 8'h00 : a + 8'h01;
  endfunction

  spsf_pkg::spsf_state_t st_r;
  logic [7:0] op_r, sh_r, tx_r, sr_r;
  logic [2:0] bit_r;
  logic armed_r, wel_r, wel_kill_r, r_bit_r, tx_en_r, step_r;
  logic [6:0] ahi_r;
  logic [7:0] byte_in;
  logic byte_done;
  logic [7:0] status_view;

  assign byte_in = {sh_r[6:0], ev.si};
  assign byte_done = ev.sck_rise && armed_r && bit_r == `SPSF_BIT_LAST;
  assign status_view = `SPSF_SR_FIXED | (sr_r & `SPSF_SR_BP_MASK) | {6'h00, wel_r, 1'b0};

  // mode 3: sck is high at select, so ignore rises until sck seen low
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      armed_r <= 1'b0;
      mode3_o <= 1'b0;
    end else if (ce) begin
      if (ev.sel_fall) begin
        armed_r <= !ev.mode3;
        mode3_o <= ev.mode3;
      end else if (ev.sck_fall) begin
        armed_r <= 1'b1;
      end
    end
  end

  // bit and byte framing
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bit_r <= 3'h0;
      sh_r <= 8'h00;
    end else if (ce) begin
      if (ev.sel_fall) begin
        bit_r <= 3'h0;
        sh_r <= 8'h00;
      end else if (ev.sck_rise && armed_r) begin
        bit_r <= bit_r + 3'h1;
        sh_r <= byte_in;
      end
    end
  end

  // command sequencing
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= spsf_pkg::SPSF_OPC;
      op_r <= 8'h00;
      ahi_r <= 7'h00;
      mem_addr <= '0;
      pc_addr <= 8'h00;
      step_r <= 1'b0;
    end else if (ce) begin
      // address moves a cycle after the byte, so a write strobe still sees the old one
      step_r <= byte_done && st_r == spsf_pkg::SPSF_DAT;
      if (ev.sel_fall) begin
        st_r <= spsf_pkg::SPSF_OPC;
      end else if (step_r) begin
        if (op_r == `SPSF_OP_MEM_RD || op_r == `SPSF_OP_MEM_WR)
          mem_addr <= mem_addr + 15'h0001;
        if (op_r == `SPSF_OP_PC_RD || op_r == `SPSF_OP_PC_WR)
          pc_addr <= pc_next(pc_addr);
      end else if (byte_done) begin
        case (st_r)
          spsf_pkg::SPSF_OPC: begin
            op_r <= byte_in;
            if (!op_known(byte_in)) st_r <= spsf_pkg::SPSF_IGN;
            else if (byte_in == `SPSF_OP_MEM_RD || byte_in == `SPSF_OP_MEM_WR)
              st_r <= spsf_pkg::SPSF_AHI;
            else if (byte_in == `SPSF_OP_PC_RD || byte_in == `SPSF_OP_PC_WR)
              st_r <= spsf_pkg::SPSF_ALO;
            else st_r <= spsf_pkg::SPSF_DAT;
          end
          spsf_pkg::SPSF_AHI: begin
            ahi_r <= byte_in[6:0];
            st_r <= spsf_pkg::SPSF_ALO;
          end
          spsf_pkg::SPSF_ALO: begin
            if (op_r == `SPSF_OP_PC_RD || op_r == `SPSF_OP_PC_WR) pc_addr <= byte_in;
            else mem_addr <= {ahi_r, byte_in};
            st_r <= spsf_pkg::SPSF_DAT;
          end
          spsf_pkg::SPSF_DAT: st_r <= spsf_pkg::SPSF_DAT;
          spsf_pkg::SPSF_IGN: st_r <= spsf_pkg::SPSF_IGN;
          default: st_r <= spsf_pkg::SPSF_IGN;
        endcase
      end
    end
  end

  // write latch, status and companion writes; write ops drop the latch at deselect
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wel_r <= 1'b0;
      wel_kill_r <= 1'b0;
      sr_r <= 8'h00;
      mem_we <= 1'b0;
      pc_we <= 1'b0;
      mem_wdata <= 8'h00;
      pc_wdata <= 8'h00;
      r_bit_r <= 1'b0;
      time_capture <= 1'b0;
    end else if (ce) begin
      mem_we <= 1'b0;
      pc_we <= 1'b0;
      time_capture <= 1'b0;
      if (ev.sel_fall) wel_kill_r <= 1'b0;
      else if (!ev.sel && wel_kill_r) begin
        wel_r <= 1'b0;
        wel_kill_r <= 1'b0;
      end
      if (byte_done && st_r == spsf_pkg::SPSF_OPC) begin
        if (byte_in == `SPSF_OP_WLATCH_SET) wel_r <= 1'b1;
        if (byte_in == `SPSF_OP_WLATCH_CLR) wel_r <= 1'b0;
      end
      if (byte_done && st_r == spsf_pkg::SPSF_DAT && wel_r) begin
        case (op_r)
          `SPSF_OP_SR_WR: begin
            sr_r <= byte_in & `SPSF_SR_BP_MASK;
            wel_kill_r <= 1'b1;
          end
          `SPSF_OP_MEM_WR: begin
            mem_wdata <= byte_in;
            mem_we <= 1'b1;
            wel_kill_r <= 1'b1;
          end
          `SPSF_OP_PC_WR: begin
            pc_wdata <= byte_in;
            pc_we <= 1'b1;
            wel_kill_r <= 1'b1;
            if (pc_addr == `SPSF_PC_RTC_CTRL) begin
              r_bit_r <= byte_in[`SPSF_RTC_R_BIT];
              time_capture <= byte_in[`SPSF_RTC_R_BIT] && !r_bit_r;
            end
          end
          default: wel_kill_r <= wel_kill_r;
        endcase
      end
    end
  end

  // output shifter; reads prefetch on last rising edge, shift on falling edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_r <= 8'h00;
      tx_en_r <= 1'b0;
      so_o <= 1'b0;
      so_oe_n <= 1'b1;
      mem_re <= 1'b0;
      pc_re <= 1'b0;
    end else if (ce) begin
      // fetch in the same cycle the address settles; rdata is a combinational lookup
      mem_re <= ev.sel && op_r == `SPSF_OP_MEM_RD &&
                ((byte_done && st_r == spsf_pkg::SPSF_ALO) || step_r);
      pc_re <= ev.sel && op_r == `SPSF_OP_PC_RD &&
               ((byte_done && st_r == spsf_pkg::SPSF_ALO) || step_r);
      if (!ev.sel || ev.sel_fall) begin
        tx_en_r <= 1'b0;
        so_oe_n <= 1'b1;
      end else if (byte_done) begin
        tx_en_r <= 1'b0;
        if ((st_r == spsf_pkg::SPSF_OPC && byte_in == `SPSF_OP_SR_RD) ||
            (st_r == spsf_pkg::SPSF_DAT && op_r == `SPSF_OP_SR_RD)) begin
          tx_r <= status_view;
          tx_en_r <= 1'b1;
        end
      end else if (mem_re || pc_re) begin
        tx_r <= mem_re ? mem_rdata : pc_rdata;
        tx_en_r <= 1'b1;
      end else if (ev.sck_fall && tx_en_r && st_r != spsf_pkg::SPSF_IGN) begin
        so_o <= tx_r[7];
        tx_r <= {tx_r[6:0], 1'b0};
        so_oe_n <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) status_o <= `SPSF_SR_FIXED;
    else if (ce) status_o <= status_view;
  end
endmodule // spsf_front
`default_nettype wire

//--- tb/spsf_front_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module spsf_front_assertions (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic so_o,
  input wire logic so_oe_n,
  input wire logic mem_we,
  input wire logic pc_we,
  input wire logic time_capture,
  input wire logic [7:0] status_o,
  input wire logic mode3_o
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // sync path is 2-3 cycles, so allow 8 before judging idle
  sequence s_idle;
    cs_n [*8];
  endsequence
  sequence s_fall_seen;
    !sck && $past(sck, 5);
  endsequence
  a_idle_tristate: assert property (s_idle |-> so_oe_n)
    else $error("output driven while deselected");
  a_idle_quiet: assert property (s_idle |-> !mem_we && !pc_we)
    else $error("write strobe while deselected");
  a_drive_on_fall: assert property ($fell(so_oe_n) |-> !cs_n ##0 s_fall_seen)
    else $error("output enabled off a clock fall");
  a_shift_on_fall: assert property ($changed(so_o) && !so_oe_n |-> s_fall_seen)
    else $error("output bit changed off a clock fall");
  a_mode_hold: assert property ($changed(mode3_o) |-> !cs_n)
    else $error("mode changed while deselected");
  a_mode_pick: assert property ($fell(cs_n) |-> ##6 mode3_o == $past(sck, 6))
    else $error("mode does not follow clock level at select");
  a_status_fixed: assert property (status_o[7:4] == 4'h4 && !status_o[0])
    else $error("fixed status bits wrong");
  a_we_single: assert property (mem_we || pc_we |=> !mem_we && !pc_we)
    else $error("write strobe longer than one cycle");
  a_capture_pulse: assert property (time_capture |=> !time_capture)
    else $error("capture pulse longer than one cycle");
endmodule // spsf_front_assertions
bind spsf_front spsf_front_assertions i_chk (.mclk, .rst_n, .cs_n, .sck, .so_o, .so_oe_n,
  .mem_we, .pc_we, .time_capture, .status_o, .mode3_o);
`default_nettype wire

//--- tb/spsf_host.sv
`timescale 1ns/1ns
`default_nettype none
module spsf_host (
  input wire logic mclk,
  output logic cs_n,
  output logic sck,
  output logic si,
  input wire logic so
);
  logic mode3;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    mode3 = 1'b0;
  end
  task automatic wt(int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic sel(bit m3);
    mode3 = m3;
    sck = m3;
    wt(8);
    cs_n = 1'b0;
    wt(8);
  endtask
  // 80 ns half period, bits out msb first, read back on the rise
  task automatic xfer(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      sck = 1'b0;
      si = d[i];
      wt(8);
      sck = 1'b1;
      q[i] = so;
      wt(8);
    end
  endtask
  task automatic desel();
    sck = mode3;
    wt(8);
    cs_n = 1'b1;
    si = ~si;
    wt(16);
  endtask
endmodule // spsf_host
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module tb;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  wire cs_n, sck, si, so_o, so_oe_n, mem_we, mem_re, pc_we, pc_re, time_capture, mode3_o;
  wire [14:0] mem_addr;
  wire [7:0] mem_wdata, pc_addr, pc_wdata, status_o;
  int mismatches = 0, n_checks = 0, n_we, n_cap, n_oe, n_re;
  logic [14:0] wa;
  logic [7:0] wd;
  logic [15:0] rx;
  always #5 mclk = ~mclk;
  spsf_front i_dut (.mclk, .rst_n, .ce(1'b1), .cs_n, .sck, .si, .so_o, .so_oe_n,
    .mem_addr, .mem_wdata, .mem_we, .mem_re, .mem_rdata(mem_addr[14:7] ^ mem_addr[7:0]),
    .pc_addr, .pc_wdata, .pc_we, .pc_re, .pc_rdata(pc_addr + 8'h30), .time_capture,
    .status_o, .mode3_o);
  // no pull on the line: a released output shows the opposite level
  spsf_host i_host (.mclk, .cs_n, .sck, .si, .so(so_oe_n ? ~so_o : so_o));
  always @(posedge mclk) begin
    if (mem_we) begin n_we++; wa = mem_addr; wd = mem_wdata; end
    if (pc_we) begin n_we++; wa = {7'h00, pc_addr}; wd = pc_wdata; end
    if (time_capture) n_cap++;
    if (!so_oe_n) n_oe++;
    if (mem_re || pc_re) n_re++;
  end
  task automatic op(bit m3, int n, logic [39:0] tx);
    logic [7:0] q;
    rx = 16'h0000;
    n_we = 0; n_cap = 0; n_oe = 0; n_re = 0;
    i_host.sel(m3);
    for (int k = n - 1; k >= 0; k--) begin
      i_host.xfer(tx[k*8+:8], q);
      rx = {rx[7:0], q};
    end
    i_host.desel();
  endtask
  task automatic t_read(bit m3);
    op(m3, 5, {8'h03, 16'hc123, 16'h0000});
    `CHK(rx, {8'h82 ^ 8'h23, 8'h82 ^ 8'h24})
    `CHK(mode3_o, m3)
    `CHK(n_re, 3)
  endtask
  task automatic t_latch();
    op(0, 1, 40'h06);
    op(1, 2, 40'h0500);
    `CHK(rx[7:0], 8'h42)
    op(0, 1, 40'h04);
    op(0, 2, 40'h0500);
    `CHK(rx[7:0], 8'h40)
  endtask
  task automatic t_write();
    op(0, 1, 40'h06);
    op(1, 4, {8'h02, 16'h8010, 8'ha5});
    `CHK({n_we, wa, wd}, {32'd1, 15'h0010, 8'ha5})
    op(0, 4, {8'h02, 16'h0011, 8'h5a});
    `CHK(n_we, 0)
  endtask
  task automatic t_comp();
    op(0, 1, 40'h06);
    op(0, 3, {8'h12, 8'h00, 8'h01});
    `CHK({n_cap, wa, wd}, {32'd1, 15'h0000, 8'h01})
    op(1, 4, {8'h13, 8'h1d, 16'h0000});
    `CHK(rx, 16'h4d30)
    `CHK(n_re, 3)
  endtask
  task automatic t_bad();
    logic [7:0] q;
    op(0, 4, {8'hff, 8'h03, 16'h0000});
    `CHK({n_oe, n_we}, 64'd0)
    n_oe = 0;
    i_host.xfer(8'h03, q);
    `CHK(n_oe, 0)
    op(1, 5, {8'h03, 16'h0000, 16'h0000});
    `CHK(rx, 16'h0001)
  endtask
  task automatic t_status();
    op(0, 1, 40'h06);
    op(1, 2, 40'h01ff);
    i_host.wt(8);
    `CHK(status_o, 8'h4c)
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    i_host.wt(4);
    t_read(1'b0);
    t_read(1'b1);
    t_latch();
    t_write();
    t_comp();
    t_bad();
    t_status();
    print_verdict();
  end
  initial begin
    #600000;
    mismatches++;
    print_verdict();
  end
endmodule // tb
`default_nettype wire
